// [verilog/timer_capture_compare.sv]
`timescale 1ns/1ps
`include "timer_defines.svh"

// Overview of operation
// [R01] Counter runs only while run bit set
// [R02] Paired-PWM stop-on-match clears run bit
// [R03] Mode bit 6 reads one, ignores writes
// [R04] Buffer select B makes D buffer B
// [R05] Buffer select A makes C buffer A
// [R06] Paired-PWM mode overrides I/O control settings
// [R07] Sixteen-bit up-counter, prescaled, resets to zero
// [R08] Clear-on-match zeroes counter at match A
// [R09] Wrap sets overflow flag, optional interrupt
// [R10] Software uses whole words for counter, registers
// [R11] Compare equality sets match flag, interrupt
// [R12] Capture edge loads counter, sets flag
// [R13] Buffered compare A reloads from C
// [R14] General registers reset to all ones
// [R15] Match fires when counter leaves equal value
// [R16] Match drives selected level on pin
// [R17] C pin select chooses pin A or C
// [R18] C function selects compare or capture
// [R19] C actions: none, low, high, toggle
// [R20] C capture edges: rising, falling, both
// [R21] Buffer pair shares same function setting
// [R22] Flag clears by zero write after read

module timer_capture_compare (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Timer pins
  input  wire logic        timer_pin_a_in,
  output logic             timer_pin_a_out,
  output logic             timer_pin_a_oe,
  input  wire logic        timer_pin_b_in,
  output logic             timer_pin_b_out,
  output logic             timer_pin_b_oe,
  input  wire logic        timer_pin_c_in,
  output logic             timer_pin_c_out,
  output logic             timer_pin_c_oe,
  input  wire logic        timer_pin_d_in,
  output logic             timer_pin_d_out,
  output logic             timer_pin_d_oe,
  // Interrupt request
  output logic             irq_req
);
  import timer_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0]  mode_reg;
  logic [7:0]  ctrl_one_reg;
  logic [7:0]  ctrl_two_reg;
  logic [7:0]  io_zero_reg;
  logic [7:0]  io_one_reg;
  logic [4:0]  irq_en_reg;
  logic [4:0]  flag_reg;
  logic [4:0]  seen_reg;
  count_t      cnt_reg;
  count_t      gr_reg [0:3];
  logic [31:0] rd_next;
  logic        rd_hit;
  logic [3:0]  pin_next;
  logic [3:0]  oe_next;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic        wr_cnt;
  logic        wr_mode;
  logic        wr_stat;
  logic        rd_stat;
  logic [3:0]  wr_gr;
  logic        tick;
  logic        run;
  logic        paired_on;
  logic        c_on_pin_c;
  logic        stop_evt;
  logic        ovf_evt;
  logic [3:0]  fn;
  logic [1:0]  act [0:3];
  logic [3:0]  buffered;
  logic [3:0]  is_cap;
  logic [3:0]  rise;
  logic [3:0]  fall;
  logic [3:0]  edge_hit;
  logic [3:0]  cmp_evt;
  logic [3:0]  cap_evt;
  logic [4:0]  ev;
  logic [4:0]  clr;
  logic [3:0]  pin_in;

  ////////////////////////////////////////////////////////////////////////////////
  // APB decode

  assign access  = psel & penable;
  assign wr_en   = access & pready & pwrite;
  assign rd_en   = access & pready & ~pwrite;
  assign wr_cnt  = wr_en & (paddr == `OFS_COUNTER);
  assign wr_mode = wr_en & (paddr == `OFS_MODE);
  assign wr_stat = wr_en & (paddr == `OFS_STATUS);
  assign rd_stat = rd_en & (paddr == `OFS_STATUS);
  assign wr_gr   = {wr_en & (paddr == `OFS_GR_D), wr_en & (paddr == `OFS_GR_C),
                    wr_en & (paddr == `OFS_GR_B), wr_en & (paddr == `OFS_GR_A)};

  always_comb begin
    rd_hit  = 1'b1;
    rd_next = 32'h0000_0000;
    case (paddr)
      `OFS_MODE:     rd_next[7:0]  = mode_reg | `MODE_FIXED; // see [R03]
      `OFS_CTRL_ONE: rd_next[7:0]  = ctrl_one_reg;
      `OFS_CTRL_TWO: rd_next[7:0]  = ctrl_two_reg;
      `OFS_IO_ZERO:  rd_next[7:0]  = io_zero_reg;
      `OFS_IO_ONE:   rd_next[7:0]  = io_one_reg;
      `OFS_STATUS:   rd_next[7:0]  = {flag_reg[4], 3'h0, flag_reg[3:0]};
      `OFS_IRQ_EN:   rd_next[7:0]  = {irq_en_reg[4], 3'h0, irq_en_reg[3:0]};
      `OFS_COUNTER:  rd_next[15:0] = cnt_reg;
      `OFS_GR_A:     rd_next[15:0] = gr_reg[0];
      `OFS_GR_B:     rd_next[15:0] = gr_reg[1];
      `OFS_GR_C:     rd_next[15:0] = gr_reg[2];
      `OFS_GR_D:     rd_next[15:0] = gr_reg[3];
      default:       rd_hit        = 1'b0;
    endcase
  end

  // One wait state so read data leaves a flop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= access & ~pready;
      pslverr <= access & ~pready & ~rd_hit;
      if (access & ~pready & ~pwrite) begin
        prdata <= rd_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers

  assign run        = mode_reg[`MODE_RUN_BIT];
  assign paired_on  = ~mode_reg[`MODE_PWM_BIT];
  assign c_on_pin_c = io_one_reg[`IO_C_PIN_BIT];
  assign stop_evt   = paired_on & ctrl_two_reg[`CTRL_TWO_STOP] & (|cmp_evt);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= `MODE_RST;
    end else if (wr_mode) begin
      mode_reg <= (pwdata[7:0] & `MODE_WMASK) | `MODE_FIXED; // see [R01] see [R03]
    end else if (stop_evt) begin
      mode_reg[`MODE_RUN_BIT] <= 1'b0; // see [R02]
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_one_reg <= `CTRL_ONE_RST;
      ctrl_two_reg <= `CTRL_TWO_RST;
      io_zero_reg  <= `IO_ZERO_RST;
      io_one_reg   <= `IO_ONE_RST;
      irq_en_reg   <= 5'h00;
    end else if (wr_en) begin
      case (paddr)
        `OFS_CTRL_ONE: ctrl_one_reg <= pwdata[7:0] & `CTRL_ONE_WMASK;
        `OFS_CTRL_TWO: ctrl_two_reg <= pwdata[7:0] & `CTRL_TWO_WMASK;
        `OFS_IO_ZERO:  io_zero_reg  <= pwdata[7:0] & `IO_ZERO_WMASK;
        `OFS_IO_ONE:   io_one_reg   <= pwdata[7:0] & `IO_ONE_WMASK;
        `OFS_IRQ_EN:   irq_en_reg   <= {pwdata[`STAT_OVF_BIT], pwdata[`STAT_MATCH]};
        default:       ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Channel decode and events

  prescaler u_prescaler (
    .clk   (clk),
    .rst_b (rst_b),
    .sel   (clk_sel_e'(ctrl_one_reg[`CTRL_ONE_SEL])),
    .tick  (tick)
  );

  assign pin_in = {timer_pin_d_in, timer_pin_c_in, timer_pin_b_in, timer_pin_a_in};

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_edge
      pin_edge u_edge (
        .clk    (clk),
        .rst_b  (rst_b),
        .pin_in (pin_in[g]),
        .rise   (rise[g]),
        .fall   (fall[g])
      );
    end
  endgenerate

  assign fn       = {io_one_reg[`IO_HI_FN_BIT], io_one_reg[`IO_LO_FN_BIT],
                     io_zero_reg[`IO_HI_FN_BIT], io_zero_reg[`IO_LO_FN_BIT]};
  assign act[0]   = io_zero_reg[`IO_LO_ACT];
  assign act[1]   = io_zero_reg[`IO_HI_ACT];
  assign act[2]   = io_one_reg[`IO_LO_ACT];
  assign act[3]   = io_one_reg[`IO_HI_ACT];
  assign buffered = {mode_reg[`MODE_BUFB_BIT], mode_reg[`MODE_BUFA_BIT], 2'b00}; // see [R04] see [R05]

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      // Paired-PWM forces every channel to compare
      is_cap[i]   = ~paired_on & fn[i]; // see [R06]
      edge_hit[i] = act[i][1] ? (rise[i] | fall[i]) : (act[i][0] ? fall[i] : rise[i]); // see [R20]
      // Fire on the count edge that leaves the equal value
      cmp_evt[i]  = run & tick & (cnt_reg == gr_reg[i]) & ~is_cap[i] & ~buffered[i]; // see [R11] see [R15]
      cap_evt[i]  = is_cap[i] & ~buffered[i] & edge_hit[i]; // see [R12]
    end
    // Register C only captures when it owns pin C
    is_cap[2]  = ~paired_on & fn[2] & c_on_pin_c; // see [R17] see [R18]
    cmp_evt[2] = run & tick & (cnt_reg == gr_reg[2]) & ~is_cap[2] & ~buffered[2];
    cap_evt[2] = is_cap[2] & ~buffered[2] & edge_hit[2];
  end

  assign ovf_evt = run & tick & (cnt_reg == 16'hffff) & ~(cmp_evt[0] & ctrl_one_reg[`CTRL_ONE_CLR]) & ~wr_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and general registers

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= `COUNTER_RST; // see [R07]
    end else if (wr_cnt) begin
      cnt_reg <= pwdata[15:0];
    end else if (run & tick) begin // see [R01]
      if (cmp_evt[0] & ctrl_one_reg[`CTRL_ONE_CLR]) begin
        cnt_reg <= `COUNTER_RST; // see [R08]
      end else begin
        cnt_reg <= cnt_reg + 16'h0001; // see [R07]
      end
    end
  end

  // Hardware loads land after software writes, so they win
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 4; i++) begin
        gr_reg[i] <= `GR_RST; // see [R14]
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wr_gr[i]) begin
          gr_reg[i] <= pwdata[15:0];
        end
        if (cap_evt[i]) begin
          gr_reg[i] <= cnt_reg; // see [R12]
        end
      end
      for (int i = 0; i < 2; i++) begin
        if (buffered[i+2] & cap_evt[i]) begin
          gr_reg[i+2] <= gr_reg[i]; // see [R04] see [R05]
        end
        if (buffered[i+2] & cmp_evt[i]) begin
          gr_reg[i] <= gr_reg[i+2]; // see [R13]
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Flags and interrupt

  assign ev  = {ovf_evt, cmp_evt | cap_evt}; // see [R09] see [R11]
  assign clr = wr_stat ? (seen_reg & ~{pwdata[`STAT_OVF_BIT], pwdata[`STAT_MATCH]}) : 5'h00;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= 5'h00;
      seen_reg <= 5'h00;
      irq_req  <= 1'b0;
    end else begin
      // An event in the clearing cycle keeps the flag set
      flag_reg <= (flag_reg & ~clr) | ev; // see [R22]
      if (rd_stat) begin
        seen_reg <= seen_reg | {prdata[`STAT_OVF_BIT], prdata[`STAT_MATCH]}; // see [R22]
      end else begin
        seen_reg <= seen_reg & ~clr;
      end
      irq_req <= |(flag_reg & irq_en_reg); // see [R09] see [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare outputs

  always_comb begin
    int tgt;
    tgt      = 0;
    pin_next = {timer_pin_d_out, timer_pin_c_out, timer_pin_b_out, timer_pin_a_out};
    if (paired_on) begin
      // Paired-PWM: B rises on match B, falls on match A
      if (cmp_evt[0]) begin
        pin_next[1] = 1'b0; // see [R06]
      end
      if (cmp_evt[1]) begin
        pin_next[1] = 1'b1;
      end
    end else begin
      for (int i = 0; i < 4; i++) begin
        tgt = ((i == 2) && !c_on_pin_c) ? 0 : i; // see [R17]
        if (cmp_evt[i]) begin
          case (out_action_e'(act[i]))
            ACT_LOW:    pin_next[tgt] = 1'b0; // see [R16] see [R19]
            ACT_HIGH:   pin_next[tgt] = 1'b1;
            ACT_TOGGLE: pin_next[tgt] = ~pin_next[tgt];
            default:    ;
          endcase
        end
      end
    end
    oe_next = paired_on ? 4'b0010 : ~is_cap & {1'b1, c_on_pin_c, 2'b11};
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {timer_pin_d_out, timer_pin_c_out, timer_pin_b_out, timer_pin_a_out} <= 4'h0;
      {timer_pin_d_oe, timer_pin_c_oe, timer_pin_b_oe, timer_pin_a_oe}     <= 4'h0;
    end else begin
      {timer_pin_d_out, timer_pin_c_out, timer_pin_b_out, timer_pin_a_out} <= pin_next;
      {timer_pin_d_oe, timer_pin_c_oe, timer_pin_b_oe, timer_pin_a_oe}     <= oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_read_ovf;
    rd_stat && prdata[`STAT_OVF_BIT];
  endsequence

  sequence s_write_ovf_zero;
    wr_stat && !pwdata[`STAT_OVF_BIT] && !ovf_evt;
  endsequence

  property p_hold_when_stopped;
    !run && !wr_cnt |=> cnt_reg == $past(cnt_reg);
  endproperty
  a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("counter moved while stopped"); // [R01]

  property p_auto_stop;
    paired_on && ctrl_two_reg[`CTRL_TWO_STOP] && cmp_evt[1] && !wr_mode |=> !run;
  endproperty
  a_auto_stop: assert property (p_auto_stop) else $error("run bit not cleared on match"); // [R02]

  property p_reserved_one;
    access && !pready && !pwrite && paddr == `OFS_MODE |=> prdata[`MODE_RSV_BIT];
  endproperty
  a_reserved_one: assert property (p_reserved_one) else $error("reserved mode bit read as zero"); // [R03]

  property p_clear_on_a;
    ctrl_one_reg[`CTRL_ONE_CLR] && cmp_evt[0] && !wr_cnt |=> cnt_reg == 16'h0000;
  endproperty
  a_clear_on_a: assert property (p_clear_on_a) else $error("counter not cleared on match A"); // [R08]

  property p_overflow;
    // Other enabled flags may raise the request too, so only the enabled case is checked
    ovf_evt |=> flag_reg[4] ##1 (irq_req || !$past(irq_en_reg[4]));
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow flag or request missing"); // [R09]

  property p_match_leaves;
    cmp_evt[1] && !wr_cnt |=> flag_reg[1] && cnt_reg != $past(cnt_reg);
  endproperty
  a_match_leaves: assert property (p_match_leaves) else $error("match fired without counter leaving"); // [R15]

  property p_capture_c;
    cap_evt[2] |=> gr_reg[2] == $past(cnt_reg) && flag_reg[2];
  endproperty
  a_capture_c: assert property (p_capture_c) else $error("capture C did not load counter"); // [R12]

  property p_buffer_a;
    buffered[2] && cmp_evt[0] |=> gr_reg[0] == $past(gr_reg[2]);
  endproperty
  a_buffer_a: assert property (p_buffer_a) else $error("buffer C not copied to A"); // [R13]

  property p_pin_high;
    cmp_evt[0] && !paired_on && act[0] == 2'b10 && c_on_pin_c |=> timer_pin_a_out;
  endproperty
  a_pin_high: assert property (p_pin_high) else $error("pin A not driven high on match"); // [R16]

  property p_clear_after_read;
    s_read_ovf ##[1:20] s_write_ovf_zero |=> !flag_reg[4];
  endproperty
  a_clear_after_read: assert property (p_clear_after_read) else $error("overflow flag not cleared"); // [R22]

  property p_no_blind_clear;
    wr_stat && !seen_reg[4] && flag_reg[4] |=> flag_reg[4];
  endproperty
  a_no_blind_clear: assert property (p_no_blind_clear) else $error("flag cleared without prior read"); // [R22]

endmodule : timer_capture_compare

// [verilog/timer_defines.svh]
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// Register byte offsets on the APB
`define OFS_MODE        8'h00
`define OFS_CTRL_ONE    8'h04
`define OFS_CTRL_TWO    8'h08
`define OFS_IO_ZERO     8'h0c
`define OFS_IO_ONE      8'h10
`define OFS_STATUS      8'h14
`define OFS_IRQ_EN      8'h18
`define OFS_COUNTER     8'h1c
`define OFS_GR_A        8'h20
`define OFS_GR_B        8'h24
`define OFS_GR_C        8'h28
`define OFS_GR_D        8'h2c

// Reset values
`define MODE_RST        8'h48
`define CTRL_ONE_RST    8'h00
`define CTRL_TWO_RST    8'h00
`define IO_ZERO_RST     8'h00
`define IO_ONE_RST      8'h08
`define COUNTER_RST     16'h0000
`define GR_RST          16'hffff

// Writable masks and fixed bits
`define MODE_WMASK      8'hb8
`define MODE_FIXED      8'h40
`define CTRL_ONE_WMASK  8'h87
`define CTRL_TWO_WMASK  8'h01
`define IO_ZERO_WMASK   8'h77
`define IO_ONE_WMASK    8'h7f

// Field positions
`define MODE_RUN_BIT    7
`define MODE_RSV_BIT    6
`define MODE_BUFB_BIT   5
`define MODE_BUFA_BIT   4
`define MODE_PWM_BIT    3
`define CTRL_ONE_CLR    7
`define CTRL_ONE_SEL    2:0
`define CTRL_TWO_STOP   0
`define IO_LO_FN_BIT    2
`define IO_HI_FN_BIT    6
`define IO_LO_ACT       1:0
`define IO_HI_ACT       5:4
`define IO_C_PIN_BIT    3
`define STAT_OVF_BIT    7
`define STAT_MATCH      3:0

`endif

// [verilog/timer_pkg.sv]
package timer_pkg;

  typedef enum logic [2:0] {
    CLK_DIV1  = 3'h0,
    CLK_DIV2  = 3'h1,
    CLK_DIV4  = 3'h2,
    CLK_DIV8  = 3'h3,
    CLK_DIV32 = 3'h4
  } clk_sel_e;

  typedef enum logic [1:0] {
    ACT_NONE   = 2'h0,
    ACT_LOW    = 2'h1,
    ACT_HIGH   = 2'h2,
    ACT_TOGGLE = 2'h3
  } out_action_e;

  typedef logic [15:0] count_t;

endpackage : timer_pkg

// [verilog/pin_edge.sv]
`timescale 1ns/1ps

module pin_edge (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // Pin and edges
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);

  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;

  // Two flops before anything looks at the pin
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      sync1_reg <= pin_in;
      sync2_reg <= sync1_reg;
      last_reg  <= sync2_reg;
    end
  end

  assign rise = sync2_reg & ~last_reg;
  assign fall = ~sync2_reg & last_reg;

endmodule : pin_edge

// [verilog/prescaler.sv]
`timescale 1ns/1ps

module prescaler (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  // Rate select and count tick
  input  wire timer_pkg::clk_sel_e sel,
  output logic                    tick
);
  import timer_pkg::*;

  logic [4:0] div_reg;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_reg <= 5'h00;
    end else begin
      div_reg <= div_reg + 5'h01;
    end
  end

  // Unused codes fall back to the slowest rate
  always_comb begin
    case (sel)
      CLK_DIV1: tick = 1'b1;
      CLK_DIV2: tick = div_reg[0];
      CLK_DIV4: tick = &div_reg[1:0];
      CLK_DIV8: tick = &div_reg[2:0];
      default:  tick = &div_reg;
    endcase
  end

endmodule : prescaler

// [test/timer_pins_model.sv]
`timescale 1ns/1ps

////////////////////////////////////////////////////////////
// Far-side pads: each pad shows the timer level while the timer drives it,
// otherwise the level from the external source
module timer_pins_model (
  // Timer side
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  // External source
  input  wire logic [3:0] ext_level,
  // Resolved pads
  output logic      [3:0] pad
);
  // Timer wins while enabled; a board would see contention if both drove
  assign pad = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : timer_pins_model

// [test/test_timer_capture_compare.sv]
`timescale 1ns/1ps
`include "timer_defines.svh"

module test_timer_capture_compare;
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, irq_req, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, v;
  logic [3:0]  pin_out, pin_oe, ext_level, pad;
  int          n_errors, n_tests, i;
  logic [1:0]  act [5] = '{2'h2, 2'h3, 2'h3, 2'h0, 2'h1};
  logic        lvl [5] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  timer_capture_compare DUT (
    .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_pin_a_in(pad[0]), .timer_pin_a_out(pin_out[0]), .timer_pin_a_oe(pin_oe[0]),
    .timer_pin_b_in(pad[1]), .timer_pin_b_out(pin_out[1]), .timer_pin_b_oe(pin_oe[1]),
    .timer_pin_c_in(pad[2]), .timer_pin_c_out(pin_out[2]), .timer_pin_c_oe(pin_oe[2]),
    .timer_pin_d_in(pad[3]), .timer_pin_d_out(pin_out[3]), .timer_pin_d_oe(pin_oe[3]),
    .irq_req(irq_req)
  );

  timer_pins_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level), .pad(pad));

  ////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  // Whole-word transfers only; the bench never issues narrow accesses
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n == 16) n_errors++;
    v        = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdm(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(name, v & m, e);
  endtask : rdm

  // Flags clear only by a zero write after a read
  task automatic clr;
    apb(1'b0, `OFS_STATUS, 32'h0);
    wr(`OFS_STATUS, 32'h0);
  endtask : clr

  task automatic test_done;
    if (n_errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    test_done;
  end

  initial begin
    rst_b     <= 1'b0;
    psel      <= 1'b0;
    penable   <= 1'b0;
    pwrite    <= 1'b0;
    paddr     <= 8'h00;
    pwdata    <= 32'h0;
    ext_level <= 4'h0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rdm("mode", `OFS_MODE, 32'hff, 32'h48);
    chk("oe_reset", {28'h0, pin_oe}, 32'hf);
    rdm("io_one", `OFS_IO_ONE, 32'hff, 32'h08);
    rdm("counter", `OFS_COUNTER, 32'hffff, 32'h0);
    for (i = 0; i < 4; i++) begin
      rdm("general", `OFS_GR_A + 8'(4 * i), 32'hffff, 32'hffff);
    end
    apb(1'b0, 8'h3c, 32'h0);
    chk("slverr", {31'h0, last_err}, 32'h1);
    wr(`OFS_MODE, 32'h00);
    rdm("mode_rsv", `OFS_MODE, 32'hff, 32'h40);
    wr(`OFS_MODE, 32'h08);
    wr(`OFS_COUNTER, 32'h0100);
    repeat (10) @(posedge clk);
    rdm("held", `OFS_COUNTER, 32'hffff, 32'h0100);
    // Equality on a stopped counter is not yet a match
    wr(`OFS_GR_A, 32'h5);
    wr(`OFS_COUNTER, 32'h5);
    wr(`OFS_CTRL_ONE, 32'h80);
    wr(`OFS_IO_ZERO, 32'h02);
    wr(`OFS_IRQ_EN, 32'h01);
    repeat (5) @(posedge clk);
    rdm("no_match", `OFS_STATUS, 32'hff, 32'h0);
    wr(`OFS_MODE, 32'h88);
    repeat (20) @(posedge clk);
    wr(`OFS_MODE, 32'h08);
    chk("pin_a", {31'h0, pin_out[0]}, 32'h1);
    chk("irq_a", {31'h0, irq_req}, 32'h1);
    apb(1'b0, `OFS_COUNTER, 32'h0);
    chk("period", 32'(v[15:0] <= 16'h0005), 32'h1);
    rdm("flag_a", `OFS_STATUS, 32'h8f, 32'h01);
    wr(`OFS_STATUS, 32'hff);
    rdm("flag_kept", `OFS_STATUS, 32'h01, 32'h01);
    wr(`OFS_STATUS, 32'h00);
    rdm("flag_clr", `OFS_STATUS, 32'h8f, 32'h0);
    repeat (2) @(posedge clk);
    chk("irq_clr", {31'h0, irq_req}, 32'h0);
    // Wrap of the counter
    wr(`OFS_CTRL_ONE, 32'h00);
    wr(`OFS_IRQ_EN, 32'h80);
    wr(`OFS_COUNTER, 32'hfffe);
    wr(`OFS_MODE, 32'h88);
    repeat (4) @(posedge clk);
    wr(`OFS_MODE, 32'h08);
    // A zero write without a prior read must leave the flag alone
    wr(`OFS_STATUS, 32'h00);
    rdm("ovf", `OFS_STATUS, 32'h80, 32'h80);
    chk("irq_ovf", {31'h0, irq_req}, 32'h1);
    clr;
    wr(`OFS_IRQ_EN, 32'h00);
    // Buffered pairs, both registers of a pair left in compare
    wr(`OFS_IO_ONE, 32'h08);
    wr(`OFS_CTRL_ONE, 32'h80);
    wr(`OFS_GR_A, 32'h4);
    wr(`OFS_GR_C, 32'h9);
    wr(`OFS_GR_B, 32'h3);
    wr(`OFS_GR_D, 32'h7);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_MODE, 32'hb8);
    repeat (30) @(posedge clk);
    wr(`OFS_MODE, 32'h38);
    rdm("buf_a", `OFS_GR_A, 32'hffff, 32'h9);
    rdm("buf_b", `OFS_GR_B, 32'hffff, 32'h7);
    // Pin C and D compare actions, one match each
    wr(`OFS_MODE, 32'h08);
    wr(`OFS_CTRL_ONE, 32'h00);
    wr(`OFS_GR_C, 32'h10);
    wr(`OFS_GR_D, 32'h10);
    for (i = 0; i < 5; i++) begin
      wr(`OFS_IO_ONE, 32'h08 | 32'(act[i]) | (32'(act[i]) << 4));
      wr(`OFS_COUNTER, 32'h8);
      wr(`OFS_MODE, 32'h88);
      repeat (30) @(posedge clk);
      wr(`OFS_MODE, 32'h08);
      chk("pin_c", {31'h0, pin_out[2]}, {31'h0, lvl[i]});
      chk("pin_d", {31'h0, pin_out[3]}, {31'h0, lvl[i]});
    end
    // Register C routed to pin A
    wr(`OFS_IO_ZERO, 32'h00);
    wr(`OFS_IO_ONE, 32'h01);
    wr(`OFS_COUNTER, 32'h8);
    wr(`OFS_MODE, 32'h88);
    repeat (30) @(posedge clk);
    wr(`OFS_MODE, 32'h08);
    chk("pin_a_by_c", {31'h0, pin_out[0]}, 32'h0);
    // Capture on pin C with a stopped counter, every edge choice
    wr(`OFS_COUNTER, 32'h0123);
    for (i = 0; i < 3; i++) begin
      wr(`OFS_IO_ONE, 32'h0c | 32'(i));
      ext_level[2] <= (i == 0);
      repeat (8) @(posedge clk);
      clr;
      wr(`OFS_GR_C, 32'hffff);
      ext_level[2] <= ~ext_level[2];
      repeat (8) @(posedge clk);
      rdm("edge_one", `OFS_STATUS, 32'h04, (i == 2) ? 32'h04 : 32'h0);
      clr;
      ext_level[2] <= ~ext_level[2];
      repeat (8) @(posedge clk);
      rdm("edge_two", `OFS_STATUS, 32'h04, 32'h04);
      rdm("captured", `OFS_GR_C, 32'hffff, 32'h0123);
    end
    // Paired PWM halts itself on the first match, which is match B
    wr(`OFS_GR_A, 32'h20);
    wr(`OFS_GR_B, 32'h10);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_CTRL_TWO, 32'h01);
    wr(`OFS_MODE, 32'h80);
    repeat (60) @(posedge clk);
    rdm("stopped", `OFS_MODE, 32'hff, 32'h40);
    chk("pwm_b", {31'h0, pin_out[1]}, 32'h1);
    chk("oe_b", {31'h0, pin_oe[1]}, 32'h1);
    chk("oe_c", {31'h0, pin_oe[2]}, 32'h0);
    test_done;
  end
endmodule : test_timer_capture_compare
